// [logic/sasp_core.sv]
// Function
// [RL1] Host supplies master clocks at 256x sample rate
// [RL2] One master clock drives modulator and filter
// [RL3] Output sample rate at most 50 kHz
// [RL4] Sample at 64x, decimate to one word
// [RL5] Master bit clock is master clock over four
// [RL6] Slave bit clock from host, 64x preferred
// [RL7] Words are 24-bit two's complement, MSB first
// [RL8] Shift on bit clock, channel by frame level
// [RL9] Left and right words sampled together
// [RL10] Format pin selects one of two formats
// [RL11] Format pin high gives I2S framing
// [RL12] Data changes after bit clock falling edges
// [RL13] Master frame clock changes on bit falling edge
// [RL14] Slave frame clock edges lead rising edges
// [RL15] High-pass filter after decimation removes DC
// [RL16] Master frame clock is master clock over 256
// [RL17] Select pin low master, high slave
// [RL18] Slave frame clock synchronous, at sample rate
// [RL19] Format low: left high, MSB at edge
// [RL20] I2S: left low, MSB one bit late
// [RL21] Zeros after LSB until next frame edge
`timescale 1ns/1ps
`include "sasp_regs.svh"

module sasp_core
	import sasp_pkg::*;
#(
	parameter int MCLK_DIV = `SASP_MCLK_DIV_MIN,
	parameter int MOD_W = `SASP_MOD_BITS,
	parameter int HPF_SHIFT = `SASP_HPF_SHIFT,
	parameter int FIFO_DEPTH = `SASP_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic slaveSel,
	input wire logic formatSelect,
	input wire logic signed [MOD_W-1:0] modLeftIn,
	input wire logic signed [MOD_W-1:0] modRightIn,
	output logic modSampleStrobe,
	input wire logic bitClockIn,
	output logic bitClockOut,
	output logic bitClockOe,
	input wire logic frameClockIn,
	output logic frameClockOut,
	output logic frameClockOe,
	output logic serialDataOut
);
	localparam int WB = `SASP_WORD_BITS;
	localparam int HB = `SASP_HPF_BITS;
	localparam int ACC_W = MOD_W + `SASP_OSR_LOG2;
	// Never run the master clock faster than the top sample rate allows
	localparam int DIV_EFF = (MCLK_DIV < `SASP_MCLK_DIV_MIN) ? `SASP_MCLK_DIV_MIN : MCLK_DIV; // RL3
	localparam int DW = (DIV_EFF > 1) ? $clog2(DIV_EFF) : 1;
	localparam logic [DW-1:0] DIV_LAST = (DW)'(DIV_EFF - 1);
	localparam logic [5:0] OSR_LAST = 6'(`SASP_OSR - 1);
	localparam logic [4:0] WB_LAST = 5'(WB - 1);
	localparam logic [4:0] WB_FULL = 5'(WB);
	localparam logic signed [HB-1:0] SAT_HI = HB'(2**(WB-1) - 1);
	localparam logic signed [HB-1:0] SAT_LO = -HB'(2**(WB-1));

	// ****************************************************************
	// Master clock and shared divider
	// ****************************************************************
	logic [DW-1:0] divCnt_reg;
	logic mclkTick;
	logic [7:0] mclkCnt_reg;
	logic [7:0] mclkCnt_next;

	// Master clock tick as an enable pulse off the system clock
	always_ff @(posedge clk) begin
		if (rst || divCnt_reg == DIV_LAST) begin
			divCnt_reg <= '0;
		end else begin
			divCnt_reg <= divCnt_reg + 1'b1;
		end
	end
	assign mclkTick = (divCnt_reg == DIV_LAST);
	assign mclkCnt_next = mclkCnt_reg + 8'h01;

	// One count of 256 master ticks feeds both bit and frame clocks
	always_ff @(posedge clk) begin
		if (rst) begin
			mclkCnt_reg <= 8'h00;
		end else if (mclkTick) begin
			mclkCnt_reg <= mclkCnt_next; // RL2
		end
	end

	// Modulator samples at every fourth master tick, 64 per frame
	assign modSampleStrobe = mclkTick && (mclkCnt_reg[1:0] == 2'b11); // RL4

	// ****************************************************************
	// Serial clocks, master or slave
	// ****************************************************************
	logic bitClockPrev_reg;
	logic fallEvent;
	logic frameAtFall;

	// Master bit clock is count bit 1, frame clock count bit 7
	assign bitClockOut = mclkCnt_reg[1]; // RL5
	assign frameClockOut = mclkCnt_reg[7]; // RL16
	// Both clocks are inputs in slave mode
	assign bitClockOe = !slaveSel; // RL17
	assign frameClockOe = !slaveSel; // RL17

	// Host bit clock is taken as synchronous, so one flop finds edges
	always_ff @(posedge clk) begin
		if (rst) begin
			bitClockPrev_reg <= 1'b0;
		end else begin
			bitClockPrev_reg <= bitClockIn;
		end
	end

	// Master falls as count bits 1:0 wrap; slave on the host edge
	always_comb begin
		if (slaveSel) begin
			fallEvent = bitClockPrev_reg && !bitClockIn; // RL6
			frameAtFall = frameClockIn; // RL14
		end else begin
			fallEvent = modSampleStrobe; // RL13
			frameAtFall = mclkCnt_next[7];
		end
	end

	// ****************************************************************
	// Decimation and high-pass, both channels in step
	// ****************************************************************
	logic [5:0] phase_reg;
	logic stall;
	logic decimDone;
	logic hpfValid_reg;
	logic fifoInReady;
	logic signed [MOD_W-1:0] modIn [2];
	logic [WB-1:0] hpfOut [2];

	assign modIn[0] = modLeftIn;
	assign modIn[1] = modRightIn;
	// Full FIFO holds the accumulators still rather than drop a word
	assign stall = hpfValid_reg && !fifoInReady;
	assign decimDone = modSampleStrobe && !stall && (phase_reg == OSR_LAST); // RL4

	// Shared phase, so both channels close their sums on the same sample
	always_ff @(posedge clk) begin
		if (rst) begin
			phase_reg <= 6'h00;
		end else if (modSampleStrobe && !stall) begin
			phase_reg <= phase_reg + 6'h01; // RL9
		end
	end

	// New pair waits here until the FIFO takes it
	always_ff @(posedge clk) begin
		if (rst) begin
			hpfValid_reg <= 1'b0;
		end else if (decimDone) begin
			hpfValid_reg <= 1'b1;
		end else if (fifoInReady) begin
			hpfValid_reg <= 1'b0;
		end
	end

	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic signed [ACC_W-1:0] acc_reg;
		logic signed [ACC_W-1:0] sum;
		logic signed [HB-1:0] xNew;
		logic signed [HB-1:0] xPrev_reg;
		logic signed [HB-1:0] y_reg;
		logic signed [HB-1:0] y_next;

		assign sum = acc_reg + ACC_W'(modIn[ch]);
		// Scale the boxcar sum up to a full-scale 24-bit word
		assign xNew = HB'($signed({sum, {(WB - ACC_W){1'b0}}}));
		// First-order DC block: y = x - x1 + y1 - y1/2^k
		assign y_next = xNew - xPrev_reg + y_reg - (y_reg >>> HPF_SHIFT); // RL15

		// Boxcar decimator, one word per 64 modulator samples
		always_ff @(posedge clk) begin
			if (rst) begin
				acc_reg <= '0;
			end else if (decimDone) begin
				acc_reg <= '0; // RL4
			end else if (modSampleStrobe && !stall) begin
				acc_reg <= sum;
			end
		end

		// Filter state moves once per decimated word
		always_ff @(posedge clk) begin
			if (rst) begin
				xPrev_reg <= '0;
				y_reg <= '0;
			end else if (decimDone) begin
				xPrev_reg <= xNew;
				y_reg <= y_next; // RL15
			end
		end

		// Clip to the output word rather than wrap on overshoot
		always_comb begin
			if (y_reg > SAT_HI) begin
				hpfOut[ch] = SAT_HI[WB-1:0];
			end else if (y_reg < SAT_LO) begin
				hpfOut[ch] = SAT_LO[WB-1:0];
			end else begin
				hpfOut[ch] = y_reg[WB-1:0]; // RL7
			end
		end
	end

	// ****************************************************************
	// Frame buffer
	// ****************************************************************
	sasp_pair_s pairIn;
	sasp_pair_s pairOut;
	logic fifoOutValid;
	logic fifoOutReady;

	assign pairIn.left = hpfOut[0];
	assign pairIn.right = hpfOut[1]; // RL9

	sasp_fifo #(
		.WIDTH($bits(sasp_pair_s)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.inData(pairIn),
		.inValid(hpfValid_reg),
		.inReady(fifoInReady),
		.outData(pairOut),
		.outValid(fifoOutValid),
		.outReady(fifoOutReady)
	);

	// ****************************************************************
	// Serializer
	// ****************************************************************
	logic lastFrame_reg;
	logic frameEdge;
	logic startLeft;
	logic [WB-1:0] edgeWord;
	logic [WB-1:0] rightHold_reg;
	logic [WB-1:0] shift_reg;
	logic [4:0] bitsLeft_reg;
	sasp_slot_e slot_reg;

	assign frameEdge = fallEvent && (frameAtFall != lastFrame_reg);
	// Left half is frame high normally, frame low in I2S
	assign startLeft = frameEdge && (formatSelect ? !frameAtFall : frameAtFall); // RL10 RL11
	// Pair is popped at the left edge; an empty buffer sends silence
	assign fifoOutReady = startLeft;
	assign edgeWord = startLeft ? (fifoOutValid ? pairOut.left : '0) : rightHold_reg; // RL8

	// Frame level as seen at the last falling edge
	always_ff @(posedge clk) begin
		if (rst) begin
			lastFrame_reg <= 1'b0;
		end else if (fallEvent) begin
			lastFrame_reg <= frameAtFall;
		end
	end

	// Right word is kept from the same pop as the left one
	always_ff @(posedge clk) begin
		if (rst) begin
			rightHold_reg <= '0;
		end else if (startLeft) begin
			rightHold_reg <= fifoOutValid ? pairOut.right : '0; // RL9
		end
	end

	// Shift path; every change waits for a bit clock falling edge
	always_ff @(posedge clk) begin
		if (rst) begin
			serialDataOut <= 1'b0;
			shift_reg <= '0;
			bitsLeft_reg <= 5'h00;
			slot_reg <= SLOT_PAD;
		end else if (fallEvent) begin // RL12
			if (frameEdge && formatSelect) begin
				serialDataOut <= 1'b0;
				shift_reg <= edgeWord;
				bitsLeft_reg <= WB_FULL;
				slot_reg <= SLOT_DELAY; // RL20
			end else if (frameEdge) begin
				serialDataOut <= edgeWord[WB-1];
				shift_reg <= {edgeWord[WB-2:0], 1'b0};
				bitsLeft_reg <= WB_LAST;
				slot_reg <= SLOT_DATA; // RL19
			end else begin
				case (slot_reg)
					SLOT_DELAY, SLOT_DATA: begin
						if (bitsLeft_reg != 5'h00) begin
							serialDataOut <= shift_reg[WB-1]; // RL7
							shift_reg <= {shift_reg[WB-2:0], 1'b0};
							bitsLeft_reg <= bitsLeft_reg - 5'h01;
							slot_reg <= SLOT_DATA;
						end else begin
							serialDataOut <= 1'b0; // RL21
							slot_reg <= SLOT_PAD;
						end
					end
					SLOT_PAD: begin
						serialDataOut <= 1'b0; // RL21
					end
					default: begin
						serialDataOut <= 1'b0;
						slot_reg <= SLOT_PAD;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	localparam logic [15:0] BC_HALF = 16'(2 * DIV_EFF);
	localparam logic [15:0] FRAME_HALF = 16'(128 * DIV_EFF);
	logic [15:0] bitRun_reg;
	logic [15:0] frameRun_reg;
	logic bitSeen_reg;
	logic frameSeen_reg;

	// Clocks since each master clock last moved; the first move after reset has no full half behind it, so it only arms
	always_ff @(posedge clk) begin
		if (rst || slaveSel) begin
			bitRun_reg <= 16'h0001;
			frameRun_reg <= 16'h0001;
			bitSeen_reg <= 1'b0;
			frameSeen_reg <= 1'b0;
		end else begin
			bitRun_reg <= (bitClockOut != $past(bitClockOut)) ? 16'h0001 : bitRun_reg + 16'h0001;
			frameRun_reg <= (frameClockOut != $past(frameClockOut)) ? 16'h0001 : frameRun_reg + 16'h0001;
			bitSeen_reg <= bitSeen_reg || (bitClockOut != $past(bitClockOut));
			frameSeen_reg <= frameSeen_reg || (frameClockOut != $past(frameClockOut));
		end
	end

	property p_bc_div;
		@(posedge clk) disable iff (rst || slaveSel) $changed(bitClockOut) && bitSeen_reg |->
			bitRun_reg == BC_HALF;
	endproperty
	a_bc_div: assert property (p_bc_div) else $error("master bit clock not master over four"); // RL5

	property p_frame_div;
		@(posedge clk) disable iff (rst || slaveSel) $changed(frameClockOut) && frameSeen_reg |->
			frameRun_reg == FRAME_HALF;
	endproperty
	a_frame_div: assert property (p_frame_div) else $error("master frame clock not master over 256"); // RL16

	property p_frame_on_fall;
		@(posedge clk) disable iff (rst || slaveSel) $changed(frameClockOut) |-> $fell(bitClockOut);
	endproperty
	a_frame_on_fall: assert property (p_frame_on_fall) else $error("frame clock moved off a falling edge"); // RL13

	property p_data_on_fall;
		@(posedge clk) disable iff (rst) $changed(serialDataOut) |-> $past(fallEvent);
	endproperty
	a_data_on_fall: assert property (p_data_on_fall) else $error("data changed without a falling edge"); // RL12

	property p_lj_msb;
		@(posedge clk) disable iff (rst) frameEdge && !formatSelect |=> serialDataOut == $past(edgeWord[WB-1]);
	endproperty
	a_lj_msb: assert property (p_lj_msb) else $error("MSB not at frame edge"); // RL19

	sequence s_i2s_gap;
		frameEdge && formatSelect ##1 !serialDataOut;
	endsequence
	property p_i2s_delay;
		@(posedge clk) disable iff (rst) frameEdge && formatSelect |-> s_i2s_gap ##0 slot_reg == SLOT_DELAY;
	endproperty
	a_i2s_delay: assert property (p_i2s_delay) else $error("I2S MSB not delayed one bit"); // RL20

	property p_pad_zero;
		@(posedge clk) disable iff (rst) fallEvent && !frameEdge && slot_reg == SLOT_PAD |=> !serialDataOut;
	endproperty
	a_pad_zero: assert property (p_pad_zero) else $error("data not zero after LSB"); // RL21

	property p_mode_pins;
		@(posedge clk) disable iff (rst) (bitClockOe == !slaveSel) && (frameClockOe == !slaveSel);
	endproperty
	a_mode_pins: assert property (p_mode_pins) else $error("clock drive does not follow mode select"); // RL17

	property p_decim_push;
		@(posedge clk) disable iff (rst) decimDone |=> hpfValid_reg && phase_reg == 6'h00;
	endproperty
	a_decim_push: assert property (p_decim_push) else $error("decimated word not presented"); // RL4

endmodule : sasp_core

// [logic/sasp_regs.svh]
`ifndef SASP_REGS_SVH
`define SASP_REGS_SVH

// ****************************************************************
// Timing figures
// ****************************************************************
`define SASP_CLK_PERIOD_NS 20
`define SASP_CLK_HZ (1000000000 / `SASP_CLK_PERIOD_NS)
`define SASP_MAX_FS_HZ 50000
`define SASP_MCLK_RATIO 256
// Least system clocks per master clock tick, rounded up
`define SASP_MCLK_DIV_MIN ((`SASP_CLK_HZ + `SASP_MCLK_RATIO * `SASP_MAX_FS_HZ - 1) / (`SASP_MCLK_RATIO * `SASP_MAX_FS_HZ))
`define SASP_BCLK_DIV 4
`define SASP_OSR 64
`define SASP_OSR_LOG2 6

// ****************************************************************
// Word layout and filter
// ****************************************************************
`define SASP_WORD_BITS 24
`define SASP_HPF_BITS 32
`define SASP_HPF_SHIFT 10
`define SASP_MOD_BITS 4
`define SASP_FIFO_DEPTH 4

`endif

// [logic/sasp_pkg.sv]
`include "sasp_regs.svh"

package sasp_pkg;

	// One stereo frame of output words, both taken at the same instant
	typedef struct packed {
		logic [`SASP_WORD_BITS-1:0] left;
		logic [`SASP_WORD_BITS-1:0] right;
	} sasp_pair_s;

	// Serializer slot phase, Gray along pad, delay, data
	typedef enum logic [1:0] {
		SLOT_PAD = 2'b00,
		SLOT_DELAY = 2'b01,
		SLOT_DATA = 2'b11
	} sasp_slot_e;

endpackage : sasp_pkg

// [logic/sasp_fifo.sv]
`timescale 1ns/1ps

module sasp_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [WIDTH-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [PW:0] DEPTH_CNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] LAST = (PW)'(DEPTH - 1);

	logic [WIDTH-1:0] memReg [DEPTH];
	logic [PW-1:0] wrPtr_reg;
	logic [PW-1:0] rdPtr_reg;
	logic [PW:0] count_reg;
	logic doWrite;
	logic doRead;

	// ****************************************************************
	// Handshake
	// ****************************************************************
	// Full and empty come straight from the occupancy count
	assign inReady = (count_reg != DEPTH_CNT);
	assign outValid = (count_reg != '0);
	assign doWrite = inValid && inReady;
	assign doRead = outValid && outReady;
	assign outData = memReg[rdPtr_reg];

	// Storage, no reset needed on the data itself
	always_ff @(posedge clk) begin
		if (doWrite) begin
			memReg[wrPtr_reg] <= inData;
		end
	end

	// Pointers wrap at the last slot, depth need not be a power of two
	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end else begin
			if (doWrite) begin
				wrPtr_reg <= (wrPtr_reg == LAST) ? '0 : wrPtr_reg + 1'b1;
			end
			if (doRead) begin
				rdPtr_reg <= (rdPtr_reg == LAST) ? '0 : rdPtr_reg + 1'b1;
			end
		end
	end

	// Occupancy
	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= '0;
		end else if (doWrite && !doRead) begin
			count_reg <= count_reg + 1'b1;
		end else if (doRead && !doWrite) begin
			count_reg <= count_reg - 1'b1;
		end
	end

	property p_fifo_bound;
		@(posedge clk) disable iff (rst) count_reg <= DEPTH_CNT;
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");

endmodule : sasp_fifo

// [bench/sasp_rx_model.sv]
`timescale 1ns/1ps

// ****************************************************************
// Audio receiver with host clock source
// ****************************************************************
module sasp_rx_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic formatSelect,
	input wire logic holdFrame,
	input wire logic bitLine,
	input wire logic frameLine,
	input wire logic dataLine,
	output logic hostBitClock,
	output logic hostFrameClock,
	output logic pairValid,
	output logic [23:0] pairLeft,
	output logic [23:0] pairRight,
	output logic [5:0] halfBits,
	output logic [7:0] padErrors
);
	logic [9:0] phaseReg;
	logic bitPrev;
	logic framePrev;
	logic synced;
	logic leftDone;
	logic [5:0] bitIdx;
	logic [5:0] curIdx;
	logic [23:0] shiftReg;
	logic inSlot;

	// One counter: 16 clk per bit, 1024 clk (256 master ticks) per frame
	always_ff @(posedge clk) begin
		if (rst) begin
			phaseReg <= 10'h000;
		end else begin
			phaseReg <= phaseReg + 10'h001;
		end
	end

	// Registered together so a frame edge lands on a bit fall, half a bit before the rise
	always_ff @(posedge clk) begin
		hostBitClock <= phaseReg[3];
		if (!holdFrame) begin
			hostFrameClock <= phaseReg[9];
		end
	end

	// Position of this bit within its half frame
	assign curIdx = (frameLine != framePrev) ? 6'h00 : bitIdx;
	assign inSlot = (curIdx >= {5'h00, formatSelect}) && (curIdx < {5'h00, formatSelect} + 6'h18);

	// Capture on the rising bit clock; a frame edge closes the previous half
	always_ff @(posedge clk) begin
		bitPrev <= bitLine;
		pairValid <= 1'b0;
		if (rst) begin
			synced <= 1'b0;
			leftDone <= 1'b0;
			padErrors <= 8'h00;
			bitIdx <= 6'h00;
			framePrev <= frameLine;
		end else if (!bitPrev && bitLine) begin
			framePrev <= frameLine;
			bitIdx <= curIdx + 6'h01;
			if (inSlot) begin
				shiftReg <= {shiftReg[22:0], dataLine};
			end else if (dataLine && synced) begin
				padErrors <= padErrors + 8'h01;
			end
			if (frameLine != framePrev) begin
				synced <= 1'b1;
				if (synced) begin
					halfBits <= bitIdx;
					if (framePrev == !formatSelect) begin
						pairLeft <= shiftReg;
						leftDone <= 1'b1;
					end else if (leftDone) begin
						pairRight <= shiftReg;
						pairValid <= 1'b1;
						leftDone <= 1'b0;
					end
				end
			end
		end
	end
endmodule : sasp_rx_model

// [bench/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
	localparam int MDIV = 4;
	typedef struct packed {
		logic slave;
		logic fmt;
		logic [3:0] l;
		logic [3:0] r;
	} sasp_tb_row_s;

	logic clk, rst, slaveSel, formatSelect, holdFrame, modSampleStrobe;
	logic signed [3:0] modLeftIn, modRightIn;
	logic bitClockOut, bitClockOe, frameClockOut, frameClockOe, serialDataOut;
	logic hostBitClock, hostFrameClock, bitLine, frameLine, pairValid;
	logic [23:0] pairLeft, pairRight;
	logic [5:0] halfBits;
	logic [7:0] padErrors;
	logic bitPrev, framePrevTb, dataPrev, seenBit, seenFrame;
	int bitCnt, frameCnt, n;
	int errors = 0;
	int checks = 0;
	sasp_tb_row_s rows [4] = '{'{1'h0, 1'h0, 4'h3, 4'h3}, '{1'h0, 1'h1, 4'h7, 4'h8},
		'{1'h1, 1'h0, 4'he, 4'h5}, '{1'h1, 1'h1, 4'h8, 4'h7}};

	// Shared lines: whoever has the enable drives
	assign bitLine = bitClockOe ? bitClockOut : hostBitClock;
	assign frameLine = frameClockOe ? frameClockOut : hostFrameClock;

	sasp_core #(.MCLK_DIV(MDIV)) i_sasp_core (.clk(clk), .rst(rst), .slaveSel(slaveSel),
		.formatSelect(formatSelect), .modLeftIn(modLeftIn), .modRightIn(modRightIn),
		.modSampleStrobe(modSampleStrobe), .bitClockIn(bitLine), .bitClockOut(bitClockOut),
		.bitClockOe(bitClockOe), .frameClockIn(frameLine), .frameClockOut(frameClockOut),
		.frameClockOe(frameClockOe), .serialDataOut(serialDataOut));

	sasp_rx_model i_sasp_rx_model (.clk(clk), .rst(rst), .formatSelect(formatSelect),
		.holdFrame(holdFrame), .bitLine(bitLine), .frameLine(frameLine), .dataLine(serialDataOut),
		.hostBitClock(hostBitClock), .hostFrameClock(hostFrameClock), .pairValid(pairValid),
		.pairLeft(pairLeft), .pairRight(pairRight), .halfBits(halfBits), .padErrors(padErrors));

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic check(string what, logic [31:0] seen, logic [31:0] expected);
		checks++;
		if (seen !== expected) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, expected, seen);
		end
	endtask : check

	task automatic results();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	// Boxcar of 64 equal samples scaled by 2^14 gives v*2^20; the filter then decays by 1/1024
	function automatic logic [23:0] expWord(logic [3:0] v, logic second);
		logic [23:0] x;
		x = {v, 20'h0_0000};
		return second ? x - {{10{v[3]}}, v, 10'h000} : x;
	endfunction : expWord

	// Bounded wait for the next complete pair
	task automatic getPair();
		int k;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (pairValid !== 1'b1 && k < 3000);
		check("pairValid", pairValid, 1);
	endtask : getPair

	task automatic runRow(sasp_tb_row_s row);
		int k;
		@(posedge clk);
		slaveSel <= row.slave;
		formatSelect <= row.fmt;
		modLeftIn <= row.l;
		modRightIn <= row.r;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		k = 0;
		getPair();
		while (pairLeft === 24'h00_0000 && pairRight === 24'h00_0000 && k < 8) begin
			getPair();
			k++;
		end
		check("leftFirst", pairLeft, expWord(row.l, 1'b0));
		check("rightFirst", pairRight, expWord(row.r, 1'b0));
		getPair();
		check("leftNext", pairLeft, expWord(row.l, 1'b1));
		check("rightNext", pairRight, expWord(row.r, 1'b1));
		check("halfBits", halfBits, 32'h0000_0020);
		check("padErrors", padErrors, 0);
		check("bitOe", bitClockOe, !row.slave);
		check("frameOe", frameClockOe, !row.slave);
		$display("test row done slave %0d format %0d", row.slave, row.fmt);
	endtask : runRow

	// ****************************************************************
	// Clock, watchdog and pin timing monitor
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#1600000;
		errors++;
		results();
	end

	// Master pins: periods, and edges only where a bit clock fall allows them
	always @(posedge clk) begin
		bitPrev <= bitLine;
		framePrevTb <= frameClockOut;
		dataPrev <= serialDataOut;
		bitCnt <= bitCnt + 1;
		frameCnt <= frameCnt + 1;
		if (rst) begin
			seenBit <= 1'b0;
			seenFrame <= 1'b0;
		end else begin
			if (dataPrev !== serialDataOut) begin
				check("dataAtFall", (bitLine == 1'b0) && (slaveSel || bitPrev), 1);
			end
			if (!slaveSel && !bitPrev && bitLine) begin
				if (seenBit) check("bitPeriod", bitCnt, 4 * MDIV);
				seenBit <= 1'b1;
				bitCnt <= 1;
			end
			if (!slaveSel && framePrevTb !== frameClockOut) begin
				check("frameAtFall", bitPrev & ~bitLine, 1);
				if (seenFrame) check("framePeriod", frameCnt, 128 * MDIV);
				seenFrame <= 1'b1;
				frameCnt <= 1;
			end
		end
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		rst = 1'b1;
		slaveSel = 1'b0;
		formatSelect = 1'b0;
		holdFrame = 1'b0;
		modLeftIn = 4'h0;
		modRightIn = 4'h0;
		repeat (8) @(posedge clk);
		foreach (rows[i]) runRow(rows[i]);
		// Mid-run reset in master mode must clear the bit clock, frame clock, data and strobe outputs
		runRow(rows[0]);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
		check("rstBit", bitClockOut, 0);
		check("rstFrame", frameClockOut, 0);
		check("rstData", serialDataOut, 0);
		check("rstStrobe", modSampleStrobe, 0);
		@(posedge clk);
		rst <= 1'b0;
		// Strobes: 64 per frame of 1024 clk
		repeat (200) @(posedge clk);
		n = 0;
		repeat (256 * MDIV) begin
			@(posedge clk);
			#1;
			if (modSampleStrobe === 1'b1) n++;
		end
		check("strobesPerFrame", n, 64);
		$display("test reset and strobe done");
		// Host freezes the frame clock: FIFO fills and stalls, pairs stay aligned after
		runRow('{1'h1, 1'h0, 4'h5, 4'h5});
		@(posedge clk);
		holdFrame <= 1'b1;
		repeat (8192) @(posedge clk);
		holdFrame <= 1'b0;
		repeat (3) getPair();
		check("stallPair", pairLeft, pairRight);
		check("stallSign", pairLeft[23], 0);
		$display("test stall done");
		results();
	end
endmodule : tb_top
